// *** logic/sar_adc_defines.vh ***
`ifndef SAR_ADC_DEFINES_VH
`define SAR_ADC_DEFINES_VH

// system clock and conversion oscillator timing
`define SYS_PERIOD_NS 40
`define OSC_PERIOD_NS 250
// conversion tick every OSC_PERIOD_NS, rounded down to whole cycles
`define OSC_DIV (`OSC_PERIOD_NS / `SYS_PERIOD_NS)
`define OSC_LAST (`OSC_DIV - 1)
`define OSC_CNT_W 3
`define OSC_CNT_RESET 3'h0

// slave address: fixed upper bits, lower bits from the select pins
`define ADDR_FIXED 3'h3
// high-speed master code 0000_1xxx, upper five bits
`define HS_CODE 5'h01

// bit counter marks within a byte
`define BIT_CNT_RESET 4'h0
`define BIT_ADDR_LAST 4'h7
`define BIT_RW 4'h8
`define BIT_ACQ_START 4'h6
`define BIT_BYTE_LAST 4'h7

// successive-approximation register: 14 result bits plus 2 sub-bits
`define SAR_W 16
`define SAR_MSB 16'h8000
`define SAR_LSB 16'h0001
`define SAR_RESET 16'h0000

// input synchroniser vector, idle bus lines high
`define SYNC_W 8
`define SYNC_RESET 8'h03
`define SYNC_SCL 0
`define SYNC_SDA 1
`define SYNC_ADDRESS_SELECT_PIN_0 2
`define SYNC_ADDRESS_SELECT_PIN_3 5
`define SYNC_REFERENCE_ADJUST_PIN 6
`define SYNC_CMP 7

`endif

// *** logic/sar_adc_conversion_sequencer.v ***
// Overview of operation
// RQ1 - 14-bit SAR result with track-and-hold, serial out
// RQ2 - conversion steps run from internal 4MHz tick
// RQ3 - acquisition in two clocks before conversion
// RQ4 - switches hold by default, track only acquiring
// RQ5 - clock line held low throughout conversion
// RQ6 - result latched in holding register during conversion
// RQ7 - master reads stored result up to 1.7MHz
// RQ8 - master slows clock for high source impedance
// RQ9 - shutdown state after power-up
// RQ10 - reference pin high disables internal reference
// RQ11 - four static pins select bus address
// RQ12 - address is 011 plus four select bits
// RQ13 - ack address, then acquire and convert
// RQ14 - D13..D6 first, then D5..D0 and sub-bits
// RQ15 - master ack continues, not-ack ends transfer
// RQ16 - fixed step count, release after register load
`timescale 1ns/100ps
`include "sar_adc_defines.vh"

module sar_adc_conversion_sequencer
(
	input wire clk_sys_i,
	input wire reset_i,
	input wire scl_i,
	output wire scl_o,
	output reg scl_oe_o,
	input wire sda_i,
	output wire sda_o,
	output reg sda_oe_o,
	input wire address_select_pin_0_i,
	input wire address_select_pin_1_i,
	input wire address_select_pin_2_i,
	input wire address_select_pin_3_i,
	input wire reference_adjust_pin_i,
	input wire comparator_i,
	output reg track_o,
	output reg shutdown_o,
	output reg int_ref_on_o,
	output reg [`SAR_W-1:0] dac_trial_o,
	output reg [`SAR_W-1:0] result_o
);

	// one-hot states
	localparam [6:0] ST_IDLE = 7'h01;
	localparam [6:0] ST_ADDR = 7'h02;
	localparam [6:0] ST_ACK = 7'h04;
	localparam [6:0] ST_CONV = 7'h08;
	localparam [6:0] ST_SEND = 7'h10;
	localparam [6:0] ST_MACK = 7'h20;
	localparam [6:0] ST_WAIT = 7'h40;
	localparam integer OSC_LAST_N = `OSC_LAST;
	localparam [`OSC_CNT_W-1:0] OSC_LAST = OSC_LAST_N[`OSC_CNT_W-1:0];

	reg [`SYNC_W-1:0] meta_reg;
	reg [`SYNC_W-1:0] sync_reg;
	reg scl_prev_reg;
	reg sda_prev_reg;
	reg [6:0] state_reg;
	reg [6:0] state_next;
	reg [3:0] bit_reg;
	reg [3:0] bit_next;
	reg [7:0] shift_reg;
	reg [7:0] shift_next;
	reg second_reg;
	reg second_next;
	reg rw_zero_reg;
	reg rw_zero_next;
	reg ack_reg;
	reg ack_next;
	reg [`OSC_CNT_W-1:0] osc_reg;
	reg [`OSC_CNT_W-1:0] osc_next;
	reg [`SAR_W-1:0] mask_reg;
	reg [`SAR_W-1:0] mask_next;
	reg [`SAR_W-1:0] sar_next;
	reg [`SAR_W-1:0] result_next;
	reg [`SAR_W-1:0] sar_keep;
	reg scl_oe_next;
	reg sda_oe_next;
	reg track_next;
	reg shutdown_next;
	reg int_ref_next;

	wire scl_s;
	wire sda_s;
	wire reference_adjust_pin_s;
	wire cmp_s;
	wire [3:0] addr_pins_s;
	wire scl_rise;
	wire scl_fall;
	wire bus_start;
	wire bus_stop;
	wire osc_tick;
	wire addr_match;
	wire hs_code;

	// open-drain lines only ever pull low
	assign scl_o = 1'b0;
	assign sda_o = 1'b0;

	// two-stage synchroniser for every pin input
	always @(posedge clk_sys_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			meta_reg <= `SYNC_RESET;
			sync_reg <= `SYNC_RESET;
		end
		else
		begin
			meta_reg <= {comparator_i, reference_adjust_pin_i,
				address_select_pin_3_i, address_select_pin_2_i,
				address_select_pin_1_i, address_select_pin_0_i,
				sda_i, scl_i};
			sync_reg <= meta_reg;
		end
	end

	assign scl_s = sync_reg[`SYNC_SCL];
	assign sda_s = sync_reg[`SYNC_SDA];
	assign reference_adjust_pin_s = sync_reg[`SYNC_REFERENCE_ADJUST_PIN];
	assign cmp_s = sync_reg[`SYNC_CMP];
	assign addr_pins_s = sync_reg[`SYNC_ADDRESS_SELECT_PIN_3:`SYNC_ADDRESS_SELECT_PIN_0]; // RQ11

	// previous line levels for edge and condition detection
	always @(posedge clk_sys_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
		end
		else
		begin
			scl_prev_reg <= scl_s;
			sda_prev_reg <= sda_s;
		end
	end

	assign scl_rise = scl_s & ~scl_prev_reg;
	assign scl_fall = ~scl_s & scl_prev_reg;
	// start and stop: data changes while clock stays high
	assign bus_start = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
	assign bus_stop = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;

	// address compare against shifted-in first seven bits
	assign addr_match = (shift_reg[6:0] == {`ADDR_FIXED, addr_pins_s}); // RQ12
	assign hs_code = (shift_reg[6:2] == `HS_CODE);

	// conversion tick, independent of the bus clock
	assign osc_tick = (osc_reg == OSC_LAST); // RQ2

	// sequencer next-state logic
	always @*
	begin
		state_next = state_reg;
		bit_next = bit_reg;
		shift_next = shift_reg;
		second_next = second_reg;
		rw_zero_next = rw_zero_reg;
		ack_next = ack_reg;
		osc_next = osc_reg;
		mask_next = mask_reg;
		sar_next = dac_trial_o;
		result_next = result_o;
		sar_keep = dac_trial_o;
		scl_oe_next = scl_oe_o;
		sda_oe_next = sda_oe_o;
		track_next = track_o;
		shutdown_next = shutdown_o;
		int_ref_next = int_ref_on_o & ~reference_adjust_pin_s; // RQ10
		case (state_reg)
			ST_CONV:
			begin
				// bus conditions ignored while the clock is stretched
				if (osc_tick)
				begin
					osc_next = `OSC_CNT_RESET;
					// keep trial bit when input is at or above trial level
					if (!cmp_s)
						sar_keep = dac_trial_o & ~mask_reg;
					mask_next = mask_reg >> 1;
					sar_next = sar_keep | (mask_reg >> 1); // RQ1
					if (mask_reg == `SAR_LSB) // RQ16
					begin
						// load holding register and free the clock line on the same tick
						result_next = sar_keep; // RQ6
						shift_next = sar_keep[15:8]; // RQ14
						sda_oe_next = ~sar_keep[15];
						scl_oe_next = 1'b0; // RQ16
						bit_next = `BIT_CNT_RESET;
						second_next = 1'b0;
						shutdown_next = 1'b1;
						state_next = ST_SEND;
					end
				end
				else
					osc_next = osc_reg + 1'b1;
			end
			default:
			begin
				if (bus_stop)
				begin
					sda_oe_next = 1'b0;
					track_next = 1'b0;
					state_next = ST_IDLE;
				end
				else if (bus_start)
				begin
					sda_oe_next = 1'b0;
					track_next = 1'b0;
					bit_next = `BIT_CNT_RESET;
					state_next = ST_ADDR;
				end
				else
				begin
					case (state_reg)
						ST_ADDR:
						begin
							if (scl_rise)
							begin
								shift_next = {shift_reg[6:0], sda_s};
								bit_next = bit_reg + 1'b1;
							end
							else if (scl_fall && bit_reg == `BIT_ADDR_LAST)
							begin
								if (addr_match && !hs_code)
								begin
									// wake and track over bits eight and nine
									track_next = 1'b1; // RQ3
									shutdown_next = 1'b0;
								end
								else
									state_next = ST_WAIT;
							end
							else if (scl_fall && bit_reg == `BIT_RW)
							begin
								rw_zero_next = ~shift_reg[0];
								sda_oe_next = 1'b1; // RQ13
								state_next = ST_ACK;
							end
						end
						ST_ACK:
						begin
							if (scl_fall)
							begin
								// hold the sample and stretch the clock
								sda_oe_next = 1'b0;
								track_next = 1'b0; // RQ4
								scl_oe_next = 1'b1; // RQ5
								int_ref_next = ~reference_adjust_pin_s; // RQ10
								osc_next = `OSC_CNT_RESET;
								mask_next = `SAR_MSB;
								sar_next = `SAR_MSB;
								state_next = ST_CONV; // RQ13
							end
						end
						ST_SEND:
						begin
							if (scl_fall)
							begin
								bit_next = bit_reg + 1'b1;
								shift_next = {shift_reg[6:0], 1'b0};
								sda_oe_next = ~shift_reg[6]; // RQ7
								if (second_reg && bit_reg == `BIT_ACQ_START)
								begin
									// next sample acquires over last bit and ack
									track_next = 1'b1; // RQ3
									shutdown_next = 1'b0;
								end
								if (bit_reg == `BIT_BYTE_LAST)
								begin
									sda_oe_next = 1'b0;
									state_next = ST_MACK;
								end
							end
						end
						ST_MACK:
						begin
							if (scl_rise)
								ack_next = ~sda_s;
							else if (scl_fall)
							begin
								if (!ack_reg)
								begin
									// not-ack: hold and shut down; internal reference off only when R/W was zero
									track_next = 1'b0;
									shutdown_next = 1'b1;
									if (rw_zero_reg)
										int_ref_next = 1'b0;
									state_next = ST_WAIT; // RQ15
								end
								else if (!second_reg)
								begin
									shift_next = result_o[7:0]; // RQ14
									sda_oe_next = ~result_o[7];
									bit_next = `BIT_CNT_RESET;
									second_next = 1'b1;
									state_next = ST_SEND;
								end
								else
								begin
									// acked pair: convert again
									track_next = 1'b0; // RQ4
									scl_oe_next = 1'b1; // RQ5
									osc_next = `OSC_CNT_RESET;
									mask_next = `SAR_MSB;
									sar_next = `SAR_MSB;
									state_next = ST_CONV; // RQ15
								end
							end
						end
						default:
						begin
							// idle or waiting for the next start
							state_next = state_reg;
						end
					endcase
				end
			end
		endcase
	end

	// sequencer registers; power-up lands in shutdown
	always @(posedge clk_sys_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			state_reg <= ST_IDLE;
			bit_reg <= `BIT_CNT_RESET;
			shift_reg <= 8'h00;
			second_reg <= 1'b0;
			rw_zero_reg <= 1'b0;
			ack_reg <= 1'b0;
			osc_reg <= `OSC_CNT_RESET;
			mask_reg <= `SAR_RESET;
			dac_trial_o <= `SAR_RESET;
			result_o <= `SAR_RESET;
			scl_oe_o <= 1'b0;
			sda_oe_o <= 1'b0;
			track_o <= 1'b0; // RQ4
			shutdown_o <= 1'b1; // RQ9
			int_ref_on_o <= 1'b0; // RQ9
		end
		else
		begin
			state_reg <= state_next;
			bit_reg <= bit_next;
			shift_reg <= shift_next;
			second_reg <= second_next;
			rw_zero_reg <= rw_zero_next;
			ack_reg <= ack_next;
			osc_reg <= osc_next;
			mask_reg <= mask_next;
			dac_trial_o <= sar_next;
			result_o <= result_next;
			scl_oe_o <= scl_oe_next;
			sda_oe_o <= sda_oe_next;
			track_o <= track_next;
			shutdown_o <= shutdown_next;
			int_ref_on_o <= int_ref_next;
		end
	end

endmodule

// *** verification/conversion_monitor.sv ***
`timescale 1ns/100ps
module conversion_monitor
(
	input wire clk_sys_i,
	input wire reset_i,
	input wire scl_oe_o,
	input wire sda_oe_o,
	input wire track_o,
	input wire shutdown_o,
	input wire int_ref_on_o,
	input wire reference_adjust_pin_i,
	input wire [15:0] dac_trial_o,
	input wire [15:0] result_o
);
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (reset_i);
	// sampling switches and conversion never overlap
	chk_hold_conv: assert property (!(track_o && scl_oe_o))
		else $error("track during conversion");
	chk_stretch_len: assert property ($rose(scl_oe_o) |->
		##90 scl_oe_o ##[1:9] !scl_oe_o) else $error("stretch length");
	chk_first_trial: assert property ($rose(scl_oe_o) |->
		dac_trial_o == 16'h8000) else $error("first trial not msb");
	chk_load_end: assert property ($changed(result_o) |->
		$fell(scl_oe_o)) else $error("result load off end");
	chk_quiet_data: assert property (scl_oe_o |-> !sda_oe_o)
		else $error("data driven in stretch");
	chk_msb_out: assert property ($fell(scl_oe_o) |->
		sda_oe_o == !result_o[15]) else $error("first bit wrong");
	chk_ext_ref: assert property (reference_adjust_pin_i [*4] |->
		!int_ref_on_o) else $error("internal ref on");
	chk_awake_conv: assert property (scl_oe_o |-> !shutdown_o)
		else $error("asleep while converting");
	chk_sleep_end: assert property ($fell(scl_oe_o) |->
		shutdown_o && !track_o) else $error("no hold after end");
endmodule

bind sar_adc_conversion_sequencer conversion_monitor mon_u
(
	.clk_sys_i(clk_sys_i),
	.reset_i(reset_i),
	.scl_oe_o(scl_oe_o),
	.sda_oe_o(sda_oe_o),
	.track_o(track_o),
	.shutdown_o(shutdown_o),
	.int_ref_on_o(int_ref_on_o),
	.reference_adjust_pin_i(reference_adjust_pin_i),
	.dac_trial_o(dac_trial_o),
	.result_o(result_o)
);

// *** verification/bus_master_model.sv ***
`timescale 1ns/100ps
module bus_master_model
(
	input wire clk_i,
	input wire scl_i,
	input wire sda_i,
	output reg scl_low_o,
	output reg sda_low_o
);
	// quarter bus clock in system clocks; slower clock lengthens acquisition
	localparam integer quarter = 2;
	initial
	begin
		scl_low_o = 1'b0;
		sda_low_o = 1'b0;
	end
	// one bus clock; high phase waits out any stretch
	task clk_bit(input tx, output rx);
	begin
		repeat (quarter) @(posedge clk_i);
		sda_low_o <= !tx;
		repeat (quarter) @(posedge clk_i);
		scl_low_o <= 1'b0;
		wait (scl_i);
		repeat (quarter) @(posedge clk_i);
		rx = sda_i;
		repeat (quarter) @(posedge clk_i);
		scl_low_o <= 1'b1;
	end
	endtask
	task start_cond;
	begin
		@(posedge clk_i);
		sda_low_o <= 1'b1;
		repeat (2 * quarter) @(posedge clk_i);
		scl_low_o <= 1'b1;
	end
	endtask
	task stop_cond;
	begin
		repeat (quarter) @(posedge clk_i);
		sda_low_o <= 1'b1;
		repeat (quarter) @(posedge clk_i);
		scl_low_o <= 1'b0;
		repeat (2 * quarter) @(posedge clk_i);
		sda_low_o <= 1'b0;
	end
	endtask
	// nine clocks msb first, the ninth is the ack slot
	task byte_io(input [8:0] tx, output [8:0] rx);
		integer i;
	begin
		for (i = 8; i >= 0; i = i - 1)
			clk_bit(tx[i], rx[i]);
	end
	endtask
endmodule

// *** verification/test_sar_adc_conversion_sequencer.sv ***
`timescale 1ns/100ps
module test_sar_adc_conversion_sequencer;
	reg clk_sys_i = 1'b0;
	reg reset_i = 1'b1;
	reg [3:0] pins = 4'ha;
	reg ref_pin = 1'b0;
	reg cmp = 1'b0;
	reg [15:0] analog = 16'h0000;
	reg [8:0] rx;
	wire scl_oe, sda_oe, scl_low, sda_low, track, sleep, iref;
	wire [15:0] trial, result;
	wire scl_line = !(scl_oe || scl_low);
	wire sda_line = !(sda_oe || sda_low);
	integer miscompares = 0;
	integer compares = 0;
	always #20 clk_sys_i = !clk_sys_i;
	// comparator: input at or above the trial level
	always @(posedge clk_sys_i)
		cmp <= analog >= trial;
	sar_adc_conversion_sequencer dut_u
	(
		.clk_sys_i(clk_sys_i),
		.reset_i(reset_i),
		.scl_i(scl_line),
		.scl_o(),
		.scl_oe_o(scl_oe),
		.sda_i(sda_line),
		.sda_o(),
		.sda_oe_o(sda_oe),
		.address_select_pin_0_i(pins[0]),
		.address_select_pin_1_i(pins[1]),
		.address_select_pin_2_i(pins[2]),
		.address_select_pin_3_i(pins[3]),
		.reference_adjust_pin_i(ref_pin),
		.comparator_i(cmp),
		.track_o(track),
		.shutdown_o(sleep),
		.int_ref_on_o(iref),
		.dac_trial_o(trial),
		.result_o(result)
	);
	bus_master_model master_u
	(
		.clk_i(clk_sys_i),
		.scl_i(scl_line),
		.sda_i(sda_line),
		.scl_low_o(scl_low),
		.sda_low_o(sda_low)
	);
	task check(input [15:0] seen, input [15:0] exp);
	begin
		compares = compares + 1;
		if (seen !== exp)
		begin
			miscompares = miscompares + 1;
			$display("ERROR %0t got %h want %h", $time, seen, exp);
		end
	end
	endtask
	task close_out;
	begin
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	end
	endtask
	// two conversions back to back, acked then not-acked
	task read_twice;
	begin
		analog <= 16'h9a5b;
		master_u.start_cond;
		master_u.byte_io({3'h3, pins, 2'h3}, rx);
		check(rx[0], 1'b0);
		master_u.byte_io(9'h1fe, rx);
		check(rx[8:1], 8'h9a);
		check(result, 16'h9a5b);
		analog <= 16'h2c37;
		master_u.byte_io(9'h1fe, rx);
		check(rx[8:1], 8'h5b);
		master_u.byte_io(9'h1fe, rx);
		check(rx[8:1], 8'h2c);
		master_u.byte_io(9'h1ff, rx);
		check(rx[8:1], 8'h37);
		master_u.stop_cond;
		check(iref, 1'b1);
	end
	endtask
	// foreign address and high-speed code get no ack
	task wrong_address;
	begin
		master_u.start_cond;
		master_u.byte_io({3'h3, pins ^ 4'h1, 2'h3}, rx);
		check(rx[0], 1'b1);
		master_u.stop_cond;
		master_u.start_cond;
		master_u.byte_io(9'h011, rx);
		check(rx[0], 1'b1);
		master_u.stop_cond;
		check(sleep, 1'b1);
	end
	endtask
	// external reference, full-scale input
	task external_ref;
	begin
		@(posedge clk_sys_i) ref_pin <= 1'b1;
		analog <= 16'hffff;
		master_u.start_cond;
		master_u.byte_io({3'h3, pins, 2'h1}, rx);
		master_u.byte_io(9'h1fe, rx);
		check(rx[8:1], 8'hff);
		check(iref, 1'b0);
		master_u.byte_io(9'h1ff, rx);
		master_u.stop_cond;
	end
	endtask
	initial
	begin
		repeat (5) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		repeat (4) @(posedge clk_sys_i);
		check(sleep, 1'b1);
		check(track, 1'b0);
		read_twice;
		wrong_address;
		external_ref;
		close_out;
	end
	// watchdog against a hung bus
	initial
	begin
		#200000;
		miscompares = miscompares + 1;
		close_out;
	end
endmodule
